// File: hw/umc_channel.sv
// Purpose: One serial channel with mode registers, flow control and channel modes.
// Assumes: Same clock for receive and transmit; 1x bit timing from BIT_CLKS.
// Notes:   Stop length field is stored but the transmitter always sends one stop bit.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`include "umc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module umc_channel #(
  parameter int unsigned BIT_CLKS = `UMC_BIT_CLKS
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_serial_in,
  input  wire logic        i_clear_to_send_in_n,
  output logic             o_serial_out,
  output logic      [7:0]  o_output_pins
);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CLKS - 1);
  localparam logic [15:0] BIT_HALF = 16'(BIT_CLKS / 2);
  localparam logic [2:0]  DEPTH    = 3'(`UMC_FIFO_DEPTH);

  umc_pkg::umc_mr1_t       mr1_q;
  umc_pkg::umc_mr2_t       mr2_q;
  logic                    ptr_q;
  logic [7:0]              opr_q, output_port_config_q;
  umc_pkg::umc_rx_entry_t  fifo_q [`UMC_FIFO_DEPTH];
  logic [1:0]              wr_ptr_q, rd_ptr_q;
  logic [2:0]              cnt_q;
  logic [2:0]              acc_q;
  logic                    top_new_q, ovr_q, rx_en_q, rx_rts_neg_q;
  umc_pkg::umc_rx_state_t  rx_st_q;
  logic [15:0]             rx_cnt_q;
  logic [3:0]              rx_idx_q;
  logic [9:0]              rx_sr_q;
  logic                    rx_done_q, rx_start_ok;
  umc_pkg::umc_tx_state_t  tx_st_q;
  logic [15:0]             tx_cnt_q, rts_cnt_q, hold_cnt_q;
  logic [3:0]              tx_left_q;
  logic [10:0]             tx_sr_q;
  logic [7:0]              hold_q;
  logic                    hold_full_q, tx_en_q, tx_dis_pend_q, rts_run_q;

  // Bus access decode; everything commits at the edge that raises ack
  logic       acc_ok, wr_ok, rd_ok;
  logic [3:0] misc;
  assign acc_ok = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_ok  = acc_ok & i_wb_we & i_wb_sel[0];
  assign rd_ok  = acc_ok & ~i_wb_we;
  assign misc   = i_wb_dat[7:4];
  logic cmd_wr, ptr_rst, rx_rst, tx_rst, err_rst, rts_on, rts_off;
  assign cmd_wr  = wr_ok & (i_wb_adr == `UMC_ADR_CMD);
  assign ptr_rst = cmd_wr & (misc == `UMC_MISC_PTR_RST);
  assign rx_rst  = cmd_wr & (misc == `UMC_MISC_RX_RST);
  assign tx_rst  = cmd_wr & (misc == `UMC_MISC_TX_RST);
  assign err_rst = cmd_wr & (misc == `UMC_MISC_ERR_RST);
  assign rts_on  = cmd_wr & (misc == `UMC_MISC_RTS_ON);
  assign rts_off = cmd_wr & (misc == `UMC_MISC_RTS_OFF);

  // Channel mode decode, combinational so a change acts at once
  logic m_echo, m_local, m_remote, echo_act, multi;
  assign m_echo   = (mr2_q.chan_mode == `UMC_CM_ECHO);
  assign m_local  = (mr2_q.chan_mode == `UMC_CM_LOCAL);
  assign m_remote = (mr2_q.chan_mode == `UMC_CM_REMOTE);
  assign echo_act = m_echo | m_remote | ((hold_cnt_q != 16'h0000) & tx_en_q);
  assign multi    = (mr1_q.par_mode == `UMC_PAR_MULTI);

  logic mode_acc;
  assign mode_acc = acc_ok & (i_wb_adr == `UMC_ADR_MODE) & (i_wb_sel[0] | ~i_wb_we);
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ptr_q <= 1'b0;
      mr1_q <= `UMC_MR_RESET;
      mr2_q <= `UMC_MR_RESET;
    end else begin
      if (ptr_rst) ptr_q <= 1'b0;
      else if (mode_acc && !ptr_q) ptr_q <= 1'b1;
      if (mode_acc && i_wb_we && !ptr_q) mr1_q <= i_wb_dat[7:0];
      if (mode_acc && i_wb_we && ptr_q) mr2_q <= i_wb_dat[7:0];
    end
  end

  // Status view
  logic rx_rdy, rx_fifo_full, tx_busy, tx_rdy, tx_emt, rx_int;
  logic [2:0] err_view;
  umc_pkg::umc_rx_entry_t top;
  assign top     = fifo_q[rd_ptr_q];
  assign rx_rdy  = (cnt_q != 3'h0);
  assign rx_fifo_full   = (cnt_q == DEPTH);
  assign tx_busy = (tx_st_q == umc_pkg::TX_SHIFT);
  assign tx_rdy  = tx_en_q & ~hold_full_q & ~m_echo;
  assign tx_emt  = tx_rdy & ~tx_busy;
  assign rx_int  = mr1_q.int_sel ? rx_fifo_full : rx_rdy;
  always_comb begin
    if (m_remote) err_view = 3'h0;
    else if (mr1_q.blk_err) err_view = acc_q;
    else if (rx_rdy) err_view = {top.brk, top.fe, top.pe};
    else err_view = 3'h0;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= acc_ok;
      if (rd_ok) begin
        unique case (i_wb_adr)
          `UMC_ADR_MODE:   o_wb_dat <= {24'h000000, ptr_q ? mr2_q : mr1_q};
          `UMC_ADR_STATUS: o_wb_dat <= {24'h000000, err_view, ovr_q, tx_emt, tx_rdy,
                                        rx_fifo_full, rx_rdy};
          `UMC_ADR_DATA:   o_wb_dat <= {24'h000000, top.data};
          `UMC_ADR_OUTPUT_PORT_CONFIG:   o_wb_dat <= {24'h000000, output_port_config_q};
          `UMC_ADR_OPR:    o_wb_dat <= {24'h000000, opr_q};
          default:         o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Frame builder: start at bit 0, data, optional parity or tag, then marking
  function automatic logic [10:0] build_frame(input logic [7:0] d, input umc_pkg::umc_mr1_t m);
    logic [10:0] f;
    logic [3:0]  n;
    f = 11'h7FF;
    n = 4'h5 + {2'h0, m.bits};
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n) f[i + 1] = d[i];
    end
    unique case (m.par_mode)
      `UMC_PAR_WITH:  f[n + 4'h1] = ^(d & (8'hFF >> (2'h3 - m.bits))) ^ m.par_type;
      `UMC_PAR_FORCE: f[n + 4'h1] = m.par_type;
      `UMC_PAR_MULTI: f[n + 4'h1] = m.par_type;
      `UMC_PAR_NONE:  f[n + 4'h1] = 1'b1;
    endcase
    return f;
  endfunction : build_frame

  // Transmitter; idle line is marking, which also covers the CTS hold
  logic tx_line, par_on, cts_ok, tx_load, tx_drained;
  assign tx_line    = tx_busy ? tx_sr_q[0] : 1'b1;
  assign par_on     = (mr1_q.par_mode != `UMC_PAR_NONE);
  assign cts_ok     = ~mr2_q.cts_en | ~i_clear_to_send_in_n;
  assign tx_load    = ~tx_busy & tx_en_q & hold_full_q & cts_ok;
  assign tx_drained = tx_dis_pend_q & ~hold_full_q & ~tx_busy;
  always_ff @(posedge i_clk) begin
    if (!i_nrst || tx_rst) begin
      tx_st_q       <= umc_pkg::TX_IDLE;
      tx_cnt_q      <= 16'h0000;
      tx_left_q     <= 4'h0;
      tx_sr_q       <= 11'h7FF;
      hold_q        <= 8'h00;
      hold_full_q   <= 1'b0;
      tx_en_q       <= 1'b0;
      tx_dis_pend_q <= 1'b0;
    end else begin
      if (wr_ok && i_wb_adr == `UMC_ADR_DATA && tx_en_q && !m_echo && !hold_full_q) begin
        hold_q      <= i_wb_dat[7:0];
        hold_full_q <= 1'b1;
      end else if (tx_load) begin
        hold_full_q <= 1'b0;
      end
      if (cmd_wr && i_wb_dat[`UMC_CMD_TX_EN]) begin
        tx_en_q       <= 1'b1;
        tx_dis_pend_q <= 1'b0;
      end else if (cmd_wr && i_wb_dat[`UMC_CMD_TX_DIS]) begin
        tx_dis_pend_q <= 1'b1;
      end else if (tx_drained) begin
        tx_en_q       <= 1'b0;
        tx_dis_pend_q <= 1'b0;
      end
      unique case (tx_st_q)
        umc_pkg::TX_IDLE: if (tx_load) begin
          tx_sr_q   <= build_frame(hold_q, mr1_q);
          tx_left_q <= 4'h7 + {2'h0, mr1_q.bits} + {3'h0, par_on};
          tx_cnt_q  <= 16'h0000;
          tx_st_q   <= umc_pkg::TX_SHIFT;
        end
        umc_pkg::TX_SHIFT: begin
          if (tx_cnt_q == BIT_LAST) begin
            tx_cnt_q  <= 16'h0000;
            tx_sr_q   <= {1'b1, tx_sr_q[10:1]};
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) tx_st_q <= umc_pkg::TX_IDLE;
          end else begin
            tx_cnt_q <= tx_cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  // Auto RTS: one bit time after the drained transmitter is switched off
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rts_run_q <= 1'b0;
      rts_cnt_q <= 16'h0000;
    end else if (tx_drained && mr2_q.tx_rts) begin
      rts_run_q <= 1'b1;
      rts_cnt_q <= 16'h0000;
    end else if (rts_run_q) begin
      rts_cnt_q <= rts_cnt_q + 16'h0001;
      if (rts_cnt_q == BIT_LAST) rts_run_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      opr_q  <= 8'h00;
      output_port_config_q <= 8'h00;
    end else begin
      if (wr_ok && i_wb_adr == `UMC_ADR_OUTPUT_PORT_CONFIG) output_port_config_q <= i_wb_dat[7:0];
      if (wr_ok && i_wb_adr == `UMC_ADR_OPR_SET) opr_q <= opr_q | i_wb_dat[7:0];
      else if (wr_ok && i_wb_adr == `UMC_ADR_OPR_CLR) opr_q <= opr_q & ~i_wb_dat[7:0];
      else if (rts_on) opr_q[`UMC_RTS_PIN] <= 1'b1;
      else if (rts_off) opr_q[`UMC_RTS_PIN] <= 1'b0;
      else if (rts_run_q && rts_cnt_q == BIT_LAST) opr_q[`UMC_RTS_PIN] <= 1'b0;
    end
  end

  // Receiver; in local loopback the pin is ignored
  logic       rx_line;
  logic [3:0] rx_n, rx_total;
  assign rx_line     = m_local ? tx_line : i_serial_in;
  assign rx_n        = 4'h5 + {2'h0, mr1_q.bits};
  assign rx_total    = rx_n + {3'h0, par_on} + 4'h1;
  assign rx_start_ok = (rx_st_q == umc_pkg::RX_START) & (rx_cnt_q == BIT_HALF) & ~rx_line;
  always_ff @(posedge i_clk) begin
    if (!i_nrst || rx_rst) begin
      rx_st_q   <= umc_pkg::RX_IDLE;
      rx_cnt_q  <= 16'h0000;
      rx_idx_q  <= 4'h0;
      rx_sr_q   <= 10'h000;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      unique case (rx_st_q)
        umc_pkg::RX_IDLE: if (!rx_line) begin
          rx_cnt_q <= 16'h0000;
          rx_st_q  <= umc_pkg::RX_START;
        end
        umc_pkg::RX_START: begin
          rx_cnt_q <= rx_cnt_q + 16'h0001;
          if (rx_cnt_q == BIT_HALF) begin
            rx_cnt_q <= 16'h0000;
            rx_idx_q <= 4'h0;
            rx_st_q  <= rx_line ? umc_pkg::RX_IDLE : umc_pkg::RX_BITS;
          end
        end
        umc_pkg::RX_BITS: begin
          rx_cnt_q <= rx_cnt_q + 16'h0001;
          if (rx_cnt_q == BIT_LAST) begin
            rx_cnt_q          <= 16'h0000;
            rx_sr_q[rx_idx_q] <= rx_line;
            rx_idx_q          <= rx_idx_q + 4'h1;
            if (rx_idx_q == rx_total - 4'h1) begin
              rx_done_q <= 1'b1;
              rx_st_q   <= umc_pkg::RX_IDLE;
            end
          end
        end
        default: rx_st_q <= umc_pkg::RX_IDLE;
      endcase
    end
  end

  // Character check; still done in auto-echo
  umc_pkg::umc_rx_entry_t rx_ent;
  logic rx_par, rx_stop, push, pop;
  always_comb begin
    rx_ent.data = rx_sr_q[7:0] & (8'hFF >> (2'h3 - mr1_q.bits));
    rx_par      = rx_sr_q[rx_n];
    rx_stop     = rx_sr_q[rx_n + {3'h0, par_on}];
    rx_ent.fe   = ~rx_stop;
    rx_ent.brk  = ~rx_stop & (rx_ent.data == 8'h00) & ~(par_on & rx_par);
    unique case (mr1_q.par_mode)
      `UMC_PAR_WITH:  rx_ent.pe = rx_par ^ ^rx_ent.data ^ mr1_q.par_type;
      `UMC_PAR_FORCE: rx_ent.pe = rx_par ^ mr1_q.par_type;
      `UMC_PAR_MULTI: rx_ent.pe = rx_par;
      `UMC_PAR_NONE:  rx_ent.pe = 1'b0;
    endcase
  end
  // Disabled multidrop receiver keeps address characters only; remote loopback keeps none
  assign push = rx_done_q & ~m_remote & (rx_en_q | (multi & rx_par));
  assign pop  = rd_ok & (i_wb_adr == `UMC_ADR_DATA) & rx_rdy;

  always_ff @(posedge i_clk) begin
    if (!i_nrst || rx_rst) begin
      wr_ptr_q     <= 2'h0;
      rd_ptr_q     <= 2'h0;
      cnt_q        <= 3'h0;
      acc_q        <= 3'h0;
      top_new_q    <= 1'b0;
      ovr_q        <= 1'b0;
      rx_en_q      <= 1'b0;
      rx_rts_neg_q <= 1'b0;
    end else begin
      if (push && (!rx_fifo_full || pop)) begin
        fifo_q[wr_ptr_q] <= rx_ent;
        wr_ptr_q         <= wr_ptr_q + 2'h1;
      end
      if (pop) rd_ptr_q <= rd_ptr_q + 2'h1;
      cnt_q     <= cnt_q + {2'h0, push && (!rx_fifo_full || pop)} - {2'h0, pop};
      top_new_q <= (push && (cnt_q == 3'h0 || (pop && cnt_q == 3'h1))) || (pop && cnt_q > 3'h1);
      // A character reaching the top in the clear cycle still counts
      if (top_new_q) acc_q <= (err_rst ? 3'h0 : acc_q) | {top.brk, top.fe, top.pe};
      else if (err_rst) acc_q <= 3'h0;
      if (push && rx_fifo_full && !pop) ovr_q <= 1'b1;
      else if (err_rst) ovr_q <= 1'b0;
      if (cmd_wr && i_wb_dat[`UMC_CMD_RX_EN]) rx_en_q <= 1'b1;
      else if (cmd_wr && i_wb_dat[`UMC_CMD_RX_DIS]) rx_en_q <= 1'b0;
      if (mr1_q.rts_ctl && rx_start_ok && rx_fifo_full) rx_rts_neg_q <= 1'b1;
      else if (!rx_fifo_full) rx_rts_neg_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) hold_cnt_q <= 16'h0000;
    else if (rx_done_q && (m_echo || m_remote)) hold_cnt_q <= BIT_HALF;
    else if (hold_cnt_q != 16'h0000) hold_cnt_q <= hold_cnt_q - 16'h0001;
  end

  // Serial output re-clocks the pin while echoing
  always_ff @(posedge i_clk) begin
    if (!i_nrst) o_serial_out <= 1'b1;
    else if (m_local) o_serial_out <= 1'b1;
    else if (echo_act) o_serial_out <= i_serial_in;
    else o_serial_out <= tx_line;
  end

  // Pins are active low copies of the port bits; pin 4 can show the receive interrupt and RTS is gated by flow control
  logic [7:0] pin_d;
  for (genvar g = 0; g < 8; g++) begin : g_pin
    if (g == `UMC_RTS_PIN) begin : g_rts
      assign pin_d[g] = ~(opr_q[g] & ~rx_rts_neg_q);
    end else if (g == `UMC_INT_PIN) begin : g_int
      assign pin_d[g] = output_port_config_q[g] ? ~rx_int : ~opr_q[g];
    end else begin : g_plain
      assign pin_d[g] = ~opr_q[g];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_nrst) o_output_pins <= 8'hFF;
    else o_output_pins <= pin_d;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_mode_first;
    mode_acc && !ptr_q && !ptr_rst;
  endsequence
  sequence s_tx_drained;
    tx_drained && mr2_q.tx_rts;
  endsequence
  property p_ptr_move; s_mode_first |=> ptr_q; endproperty
  a_ptr_move: assert property (p_ptr_move) else $error("pointer did not advance");
  property p_ptr_rst; ptr_rst |=> !ptr_q; endproperty
  a_ptr_rst: assert property (p_ptr_rst) else $error("pointer not reset");
  property p_flow; $rose(rx_rts_neg_q) |=> o_output_pins[0]; endproperty
  a_flow: assert property (p_flow) else $error("flow control did not negate pin");
  property p_inv; ##1 o_output_pins[1] == !$past(opr_q[1]); endproperty
  a_inv: assert property (p_inv) else $error("pin not inverse of port bit");
  property p_local; m_local |=> o_serial_out; endproperty
  a_local: assert property (p_local) else $error("local loopback output not high");
  property p_echo; m_echo |=> o_serial_out == $past(i_serial_in); endproperty
  a_echo: assert property (p_echo) else $error("echo output mismatch");
  property p_no_load; m_echo && !tx_load && !tx_rst |=> $stable(hold_full_q); endproperty
  a_no_load: assert property (p_no_load) else $error("holding loaded in echo");
  property p_cts; mr2_q.cts_en && i_clear_to_send_in_n && !tx_busy |=> !tx_busy; endproperty
  a_cts: assert property (p_cts) else $error("sent while clear-to-send high");
  property p_rts_auto; s_tx_drained |=> rts_run_q ##1 rts_run_q; endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("auto RTS timer not started");
  property p_remote; m_remote |-> !push && err_view == 3'h0; endproperty
  a_remote: assert property (p_remote) else $error("remote loopback reached CPU");
  property p_err_clr; err_rst && !top_new_q && !rx_rst |=> acc_q == 3'h0; endproperty
  a_err_clr: assert property (p_err_clr) else $error("block errors not cleared");
endmodule : umc_channel
`default_nettype wire

// File: hw/umc_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the channel.
// Assumes: 32-bit classic Wishbone, byte addresses, one register per word.
// Notes:   Definitions only.
`ifndef UMC_MAP_SVH
`define UMC_MAP_SVH
`define UMC_ADR_MODE     8'h00
`define UMC_ADR_STATUS   8'h04
`define UMC_ADR_CMD      8'h08
`define UMC_ADR_DATA     8'h0C
`define UMC_ADR_OPR_SET  8'h10
`define UMC_ADR_OPR_CLR  8'h14
`define UMC_ADR_OUTPUT_PORT_CONFIG     8'h18
`define UMC_ADR_OPR      8'h1C
`define UMC_CMD_RX_EN    0
`define UMC_CMD_RX_DIS   1
`define UMC_CMD_TX_EN    2
`define UMC_CMD_TX_DIS   3
`define UMC_MISC_PTR_RST 4'h1
`define UMC_MISC_RX_RST  4'h2
`define UMC_MISC_TX_RST  4'h3
`define UMC_MISC_ERR_RST 4'h4
`define UMC_MISC_RTS_ON  4'h8
`define UMC_MISC_RTS_OFF 4'h9
`define UMC_PAR_WITH     2'h0
`define UMC_PAR_FORCE    2'h1
`define UMC_PAR_NONE     2'h2
`define UMC_PAR_MULTI    2'h3
`define UMC_CM_NORMAL    2'h0
`define UMC_CM_ECHO      2'h1
`define UMC_CM_LOCAL     2'h2
`define UMC_CM_REMOTE    2'h3
`define UMC_MR_RESET     8'h00
`define UMC_FIFO_DEPTH   4
`define UMC_CLK_HZ       50000000
`define UMC_BAUD         9600
`define UMC_BIT_CLKS     (`UMC_CLK_HZ / `UMC_BAUD)
`define UMC_RTS_PIN      0
`define UMC_INT_PIN      4
`endif

// File: hw/umc_pkg.sv
// Purpose: Types shared by the channel mode-control logic.
// Assumes: Field order matches the mode register bit layout.
// Notes:   No constants here; they live in umc_map.svh.
package umc_pkg;
  typedef struct packed {
    logic       rts_ctl;
    logic       int_sel;
    logic       blk_err;
    logic [1:0] par_mode;
    logic       par_type;
    logic [1:0] bits;
  } umc_mr1_t;
  typedef struct packed {
    logic [1:0] chan_mode;
    logic       tx_rts;
    logic       cts_en;
    logic [3:0] stop_len;
  } umc_mr2_t;
  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } umc_rx_entry_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} umc_rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} umc_tx_state_t;
endpackage : umc_pkg

// File: tb/umc_far_end.sv
// Purpose: Remote serial partner: sends and decodes frames, drives clear-to-send.
// Assumes: 8 data bits, even parity, one stop bit, BIT_CLKS clocks per bit.
// Notes:   Line idles high (marking) between frames.
`timescale 1ns/1ps
`default_nettype none
module umc_far_end #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_line,
  output logic      o_cts_n
);
  logic [9:0] got;
  int         frames;
  initial begin
    o_line = 1'b1;
    o_cts_n = 1'b0;
    frames = 0;
  end
  // Mid-bit sampling keeps us clear of edge jitter; LSB first, parity, stop
  always begin
    @(negedge i_line);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int k = 0; k < 10; k++) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      got[k] = i_line;
    end
    frames++;
  end
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int k = 0; k < 11; k++) begin
      o_line <= f[k];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
  endtask : send
  task automatic set_cts(input logic v);
    o_cts_n <= v;
  endtask : set_cts
endmodule : umc_far_end
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the channel mode-control block.
// Assumes: Wishbone answers within 50 cycles; BIT_CLKS shortened to 16.
// Notes:   Random bytes come from an LFSR with a fixed seed.
`include "umc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BC = 16;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        sin;
  logic        cts_n;
  logic        sout;
  logic [7:0]  pins;
  logic [31:0] r = 32'h000172E5;
  logic [31:0] q;
  logic [7:0]  b;
  int          num_errors = 0;
  int          compares = 0;
  int          n;
  always #10 clk = ~clk;
  umc_channel #(.BIT_CLKS(BC)) i_dut (.i_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_serial_in(sin), .i_clear_to_send_in_n(cts_n),
    .o_serial_out(sout), .o_output_pins(pins));
  umc_far_end #(.BIT_CLKS(BC)) i_far (.i_clk(clk), .i_line(sout), .o_line(sin),
    .o_cts_n(cts_n));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request held until ack is sampled high; the extra edge keeps stb low a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50) num_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic tx_chk(input logic [7:0] d);
    n = i_far.frames;
    wb(1'b1, `UMC_ADR_DATA, d);
    for (int k = 0; k < 600 && i_far.frames == n; k++) @(posedge clk);
    chk({22'h0, i_far.got}, {22'h0, 1'b1, ^d, d});
  endtask : tx_chk
  task automatic end_of_test;
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wb(1'b0, `UMC_ADR_MODE, 8'h00);
    chk(q, 32'h0);
    wb(1'b0, `UMC_ADR_MODE, 8'h00);
    chk(q, 32'h0);
    wb(1'b1, `UMC_ADR_CMD, 8'h10);
    wb(1'b1, `UMC_ADR_MODE, 8'h03);
    wb(1'b1, `UMC_ADR_MODE, 8'h0F);
    wb(1'b1, `UMC_ADR_CMD, 8'h10);
    wb(1'b0, `UMC_ADR_MODE, 8'h00);
    chk(q, 32'h03);
    wb(1'b0, `UMC_ADR_MODE, 8'h00);
    chk(q, 32'h0F);
    wb(1'b1, `UMC_ADR_OPR_SET, 8'h03);
    repeat (2) @(posedge clk);
    chk({30'h0, pins[1:0]}, 32'h0);
    wb(1'b1, `UMC_ADR_CMD, 8'h90);
    repeat (2) @(posedge clk);
    chk({31'h0, pins[0]}, 32'h1);
    wb(1'b1, `UMC_ADR_CMD, 8'h80);
    repeat (2) @(posedge clk);
    chk({31'h0, pins[0]}, 32'h0);
    wb(1'b0, 8'hF0, 8'h00);
    chk(q, 32'h0);
    wb(1'b1, `UMC_ADR_CMD, 8'h05);
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      tx_chk((i == 0) ? 8'hFF : r[7:0]);
      b = (i == 1) ? 8'h00 : r[15:8];
      i_far.send(b);
      q = 32'h0;
      for (int k = 0; k < 20 && q[0] !== 1'b1; k++) wb(1'b0, `UMC_ADR_STATUS, 8'h00);
      wb(1'b0, `UMC_ADR_DATA, 8'h00);
      chk(q, {24'h0, b});
    end
    // Clear-to-send gating: line must stay marking while the far side holds it high
    wb(1'b1, `UMC_ADR_CMD, 8'h10);
    wb(1'b1, `UMC_ADR_MODE, 8'h03);
    wb(1'b1, `UMC_ADR_MODE, 8'h10);
    i_far.set_cts(1'b1);
    n = i_far.frames;
    wb(1'b1, `UMC_ADR_DATA, 8'hA5);
    repeat (100) @(posedge clk);
    chk(i_far.frames, n);
    i_far.set_cts(1'b0);
    for (int k = 0; k < 600 && i_far.frames == n; k++) @(posedge clk);
    chk({22'h0, i_far.got}, {22'h0, 1'b1, 1'b0, 8'hA5});
    // Local loopback: the frame returns inside while the pin stays marking
    wb(1'b1, `UMC_ADR_MODE, 8'h80);
    r = lfsr(r);
    n = i_far.frames;
    wb(1'b1, `UMC_ADR_DATA, r[7:0]);
    repeat (200) @(posedge clk);
    wb(1'b0, `UMC_ADR_DATA, 8'h00);
    chk(q, {24'h0, r[7:0]});
    chk(i_far.frames, n);
    // Auto-echo: loads refused, frame comes back bit for bit
    wb(1'b1, `UMC_ADR_MODE, 8'h40);
    wb(1'b1, `UMC_ADR_DATA, 8'h5A);
    wb(1'b0, `UMC_ADR_STATUS, 8'h00);
    chk({30'h0, q[3:2]}, 32'h0);
    r = lfsr(r);
    i_far.send(r[7:0]);
    chk({22'h0, i_far.got}, {22'h0, 1'b1, ^r[7:0], r[7:0]});
    wb(1'b0, `UMC_ADR_DATA, 8'h00);
    chk(q, {24'h0, r[7:0]});
    // Remote loopback: echoed, nothing stored, no error status
    wb(1'b1, `UMC_ADR_MODE, 8'hC0);
    r = lfsr(r);
    i_far.send(r[7:0]);
    chk({22'h0, i_far.got}, {22'h0, 1'b1, ^r[7:0], r[7:0]});
    wb(1'b0, `UMC_ADR_STATUS, 8'h00);
    chk(q, 32'h0C);
    // Auto RTS: disable only once the holding register is free again
    wb(1'b1, `UMC_ADR_MODE, 8'h20);
    wb(1'b1, `UMC_ADR_CMD, 8'h80);
    r = lfsr(r);
    n = i_far.frames;
    wb(1'b1, `UMC_ADR_DATA, r[7:0]);
    q = 32'h0;
    for (int k = 0; k < 20 && q[2] !== 1'b1; k++) wb(1'b0, `UMC_ADR_STATUS, 8'h00);
    wb(1'b1, `UMC_ADR_CMD, 8'h08);
    chk({31'h0, pins[0]}, 32'h0);
    for (int k = 0; k < 600 && i_far.frames == n; k++) @(posedge clk);
    chk({22'h0, i_far.got}, {22'h0, 1'b1, ^r[7:0], r[7:0]});
    repeat (16) @(posedge clk);
    chk({31'h0, pins[0]}, 32'h0);
    repeat (24) @(posedge clk);
    chk({31'h0, pins[0]}, 32'h1);
    // Receiver flow control on a full FIFO; odd parity against an even sender, block errors
    wb(1'b1, `UMC_ADR_CMD, 8'h10);
    wb(1'b1, `UMC_ADR_MODE, 8'hA7);
    wb(1'b1, `UMC_ADR_MODE, 8'h00);
    wb(1'b1, `UMC_ADR_CMD, 8'h80);
    wb(1'b1, `UMC_ADR_OUTPUT_PORT_CONFIG, 8'h10);
    for (int i = 0; i < 5; i++) begin
      r = lfsr(r);
      if (i == 0) b = r[7:0];
      i_far.send(r[7:0]);
    end
    chk({31'h0, pins[0]}, 32'h1);
    chk({31'h0, pins[4]}, 32'h0);
    wb(1'b0, `UMC_ADR_DATA, 8'h00);
    chk(q, {24'h0, b});
    repeat (2) @(posedge clk);
    chk({31'h0, pins[0]}, 32'h0);
    for (int i = 0; i < 3; i++) wb(1'b0, `UMC_ADR_DATA, 8'h00);
    wb(1'b0, `UMC_ADR_STATUS, 8'h00);
    chk({29'h0, q[7:5]}, 32'h1);
    chk({31'h0, pins[4]}, 32'h1);
    wb(1'b1, `UMC_ADR_CMD, 8'h40);
    wb(1'b0, `UMC_ADR_STATUS, 8'h00);
    chk({29'h0, q[7:5]}, 32'h0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
